// ===== hw/rsbl_pkg.sv
package rsbl_pkg;

    // ========================================
    // data path widths and lane positions
    // ========================================
    localparam int WORD_W    = 16;
    localparam int BYTE_W    = 8;
    localparam int HI_MSB    = 15;
    localparam int HI_LSB    = 8;
    localparam int LO_MSB    = 7;
    localparam int LO_LSB    = 0;
    localparam int SYNC_W    = 11;   // bus_clock, cs_n, strobe, 8 data
    localparam int SYNC_DEPTH = 2;

    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ========================================
    // transaction phase, set by the command decoder
    // ========================================
    typedef enum logic [2:0] {
        RSBL_PH_IDLE,
        RSBL_PH_CA,
        RSBL_PH_LATENCY,
        RSBL_PH_WRITE,
        RSBL_PH_WRITE_ZL,
        RSBL_PH_READ
    } rsbl_phase_t;

    typedef struct packed {
        logic [7:0] dq;
        logic       dq_oe_n;
        logic       strobe;
        logic       strobe_oe_n;
    } rsbl_pins_t;

    localparam rsbl_pins_t PINS_IDLE = '{
        dq: 8'h00, dq_oe_n: 1'b1, strobe: 1'b0, strobe_oe_n: 1'b1
    };

    typedef struct packed {
        logic [15:0] data;
        logic [1:0]  byte_en;   // [1] upper byte, [0] lower byte
    } rsbl_wr_word_t;

    localparam rsbl_wr_word_t WR_IDLE = '{data: 16'h0000, byte_en: 2'b00};

endpackage : rsbl_pkg

// ===== hw/rsbl_sync.sv
`timescale 1ns/1ps
// ========================================
// two-stage synchroniser for pin inputs
// ========================================
module rsbl_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_in,  // system clock
    input  wire logic             rst_in,      // sync reset, high
    input  wire logic [WIDTH-1:0] async_in,    // raw pin levels
    input  wire logic [WIDTH-1:0] rst_val_in,  // idle levels loaded at reset
    output logic      [WIDTH-1:0] sync_out     // synchronised levels
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            meta_q <= rst_val_in;
            sync_q <= rst_val_in;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : rsbl_sync

// ===== hw/rsbl_lanes.sv
`timescale 1ns/1ps
// Behaviour
// - each data cycle carries one 16-bit word as two bytes, one per edge
// - register read: upper byte driven from strobe rise to strobe fall
// - register read: lower byte driven from strobe fall to next rise
// - write: upper byte taken on clock rise, lower byte on clock fall
// - register accesses are always big-endian, upper byte first
// - latency writes: strobe acts as per-byte write mask from master
// - zero-latency writes store full words; device may leave strobe off
// - strobe high masks the byte, strobe low stores it
// - device drives strobe during command-address to signal extra latency
module rsbl_lanes (
    input  wire logic                 sys_clk_in,     // 125 MHz clock
    input  wire logic                 rst_in,         // sync reset, high
    input  wire logic                 bus_clock_in,   // link clock pin
    input  wire logic                 cs_n_in,        // chip select pin, low
    input  wire logic [7:0]           dq_in,          // data pins, input
    input  wire logic                 strobe_in,      // strobe/mask pin, input
    input  wire rsbl_pkg::rsbl_phase_t phase_in,      // phase from decoder
    input  wire logic                 extra_lat_in,   // extra latency needed
    input  wire logic [15:0]          rd_word_in,     // next read word
    output rsbl_pkg::rsbl_pins_t      pins_out,       // pin drive bundle
    output logic                      rd_take_out,    // read word consumed
    output rsbl_pkg::rsbl_wr_word_t   wr_word_out,    // captured write word
    output logic                      wr_valid_out,   // write word pulse
    output logic                      cs_active_out   // synced select, high
);

    // ========================================
    // pin synchronisation
    // ========================================
    localparam int SW = rsbl_pkg::SYNC_W;

    logic [SW-1:0] raw_w;
    logic [SW-1:0] syn_w;

    assign raw_w = {bus_clock_in, cs_n_in, strobe_in, dq_in};

    // ========================================
    // idle pin levels loaded at reset
    // ========================================
    // select must reset high: a low here would fake a select for
    // the first cycles after reset, before the real pin gets through
    localparam logic [SW-1:0] PIN_IDLE_LVL = {
        1'b0,                  // link clock idle low
        1'b1,                  // select idle high
        1'b0,                  // strobe released
        rsbl_pkg::BYTE_ZERO    // data lanes
    };

    rsbl_sync #(
        .WIDTH (SW)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .async_in   (raw_w),
        .rst_val_in (PIN_IDLE_LVL),
        .sync_out   (syn_w)
    );

    logic       clk_s;
    logic       cs_n_s;
    logic       strobe_s;
    logic [7:0] dq_s;

    assign clk_s    = syn_w[SW-1];
    assign cs_n_s   = syn_w[SW-2];
    assign strobe_s = syn_w[SW-3];
    assign dq_s     = syn_w[rsbl_pkg::BYTE_W-1:0];

    // ========================================
    // edge detection on the sampled link clock
    // ========================================
    logic clk_prev_q;
    logic rise_w;
    logic fall_w;
    logic sel_w;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
        end
    end

    assign sel_w  = ~cs_n_s;
    assign rise_w = sel_w & clk_s & ~clk_prev_q;
    assign fall_w = sel_w & ~clk_s & clk_prev_q;

    // ========================================
    // phase decode
    // ========================================
    logic ph_ca_w;
    logic ph_wr_w;
    logic ph_wrzl_w;
    logic ph_rd_w;

    assign ph_ca_w   = sel_w & (phase_in == rsbl_pkg::RSBL_PH_CA);
    assign ph_wr_w   = sel_w & (phase_in == rsbl_pkg::RSBL_PH_WRITE);
    assign ph_wrzl_w = sel_w & (phase_in == rsbl_pkg::RSBL_PH_WRITE_ZL);
    assign ph_rd_w   = sel_w & (phase_in == rsbl_pkg::RSBL_PH_READ);

    // ========================================
    // write capture
    // ========================================
    // data is centred on the edge, so the sample taken with the
    // detected edge sits mid-eye
    logic [7:0] hi_byte_q;
    logic       hi_mask_q;
    logic       hi_held_q;
    logic       wr_any_w;
    logic       take_hi_w;
    logic       take_lo_w;
    logic       zl_mode_w;

    assign wr_any_w  = ph_wr_w | ph_wrzl_w;
    assign take_hi_w = wr_any_w & rise_w;
    assign take_lo_w = wr_any_w & fall_w & hi_held_q;
    assign zl_mode_w = ph_wrzl_w;

    // mask only honoured in latency writes; zero-latency keeps
    // every byte since the strobe carries no mask then
    logic hi_keep_w;
    logic lo_keep_w;

    assign hi_keep_w = zl_mode_w | ~hi_mask_q;
    assign lo_keep_w = zl_mode_w | ~strobe_s;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            hi_byte_q <= rsbl_pkg::BYTE_ZERO;
            hi_mask_q <= 1'b1;
            hi_held_q <= 1'b0;
        end else if (!sel_w) begin
            hi_held_q <= 1'b0;
        end else if (take_hi_w) begin
            hi_byte_q <= dq_s;
            hi_mask_q <= strobe_s;
            hi_held_q <= 1'b1;
        end else if (take_lo_w) begin
            hi_held_q <= 1'b0;
        end
    end

    rsbl_pkg::rsbl_wr_word_t wr_word_d;

    // upper byte first, big-endian placement
    assign wr_word_d = '{
        data:    {hi_byte_q, dq_s},
        byte_en: {hi_keep_w, lo_keep_w}
    };

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_word_out  <= rsbl_pkg::WR_IDLE;
            wr_valid_out <= 1'b0;
        end else begin
            wr_valid_out <= take_lo_w;
            if (take_lo_w) begin
                wr_word_out <= wr_word_d;
            end
        end
    end

    // ========================================
    // read launch and pin drive
    // ========================================
    // strobe and data change together on each detected edge:
    // edge aligned, so the master must delay the strobe itself
    logic [7:0] lo_byte_q;
    logic       rd_take_w;

    assign rd_take_w = ph_rd_w & rise_w;

    rsbl_pkg::rsbl_pins_t pins_d;

    always_comb begin
        pins_d = pins_out;
        if (!sel_w) begin
            pins_d = rsbl_pkg::PINS_IDLE;
        end else if (ph_ca_w) begin
            pins_d = rsbl_pkg::PINS_IDLE;
            pins_d.strobe      = extra_lat_in;
            pins_d.strobe_oe_n = 1'b0;
        end else if (ph_rd_w) begin
            pins_d.dq_oe_n     = 1'b0;
            pins_d.strobe_oe_n = 1'b0;
            if (rise_w) begin
                pins_d.dq     = rd_word_in[rsbl_pkg::HI_MSB:rsbl_pkg::HI_LSB];
                pins_d.strobe = 1'b1;
            end else if (fall_w) begin
                pins_d.dq     = lo_byte_q;
                pins_d.strobe = 1'b0;
            end
        end else begin
            // latency and write phases: strobe belongs to the master;
            // zero-latency writes also left undriven
            pins_d = rsbl_pkg::PINS_IDLE;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pins_out    <= rsbl_pkg::PINS_IDLE;
            lo_byte_q   <= rsbl_pkg::BYTE_ZERO;
            rd_take_out <= 1'b0;
        end else begin
            pins_out    <= pins_d;
            rd_take_out <= rd_take_w;
            if (rd_take_w) begin
                lo_byte_q <= rd_word_in[rsbl_pkg::LO_MSB:rsbl_pkg::LO_LSB];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cs_active_out <= 1'b0;
        end else begin
            cs_active_out <= sel_w;
        end
    end

endmodule : rsbl_lanes

// ===== dv/rsbl_lanes_monitor.sv
`timescale 1ns/1ps
// ==========
// port checks for the lane block
module rsbl_lanes_monitor (
    input wire logic                    sys_clk_in,    // clock
    input wire logic                    rst_in,        // reset
    input wire logic                    bus_clock_in,  // link clock
    input wire rsbl_pkg::rsbl_phase_t   phase_in,      // phase
    input wire logic                    extra_lat_in,  // latency
    input wire logic [15:0]             rd_word_in,    // read word
    input wire rsbl_pkg::rsbl_pins_t    pins_out,      // pins
    input wire logic                    rd_take_out,   // taken
    input wire rsbl_pkg::rsbl_wr_word_t wr_word_out,   // write word
    input wire logic                    wr_valid_out,  // write pulse
    input wire logic                    cs_active_out  // selected
);
    localparam rsbl_pkg::rsbl_phase_t RD = rsbl_pkg::RSBL_PH_READ,
        WR = rsbl_pkg::RSBL_PH_WRITE, ZL = rsbl_pkg::RSBL_PH_WRITE_ZL,
        CA = rsbl_pkg::RSBL_PH_CA;
    wire logic [7:0] hi_w = rd_word_in[15:8];
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    rd_hi_a: assert property (rd_take_out |->
        !pins_out.dq_oe_n && pins_out.strobe && pins_out.dq == $past(hi_w))
        else $error("read upper byte wrong");
    rd_take_a: assert property (
        $rose(bus_clock_in) && phase_in == RD && cs_active_out
        |-> ##[2:4] rd_take_out) else $error("read word not taken");
    rd_lo_a: assert property (
        $fell(bus_clock_in) && phase_in == RD && cs_active_out |-> ##[2:4]
        (!pins_out.strobe && pins_out.dq == rd_word_in[7:0]))
        else $error("read lower byte wrong");
    ca_drive_a: assert property (
        (phase_in == CA && cs_active_out) [*2] |-> !pins_out.strobe_oe_n
        && pins_out.strobe == $past(extra_lat_in)) else $error("ca strobe");
    wr_fall_a: assert property (
        $fell(bus_clock_in) && cs_active_out && (phase_in == WR
        || phase_in == ZL) |-> ##[2:4] wr_valid_out) else $error("no word");
    wr_pulse_a: assert property (
        wr_valid_out |=> !wr_valid_out) else $error("write pulse long");
    zl_full_a: assert property (
        wr_valid_out && phase_in == ZL |-> wr_word_out.byte_en == 2'h3)
        else $error("zero latency word masked");
    zl_quiet_a: assert property (
        (phase_in == ZL) [*2] |-> pins_out.strobe_oe_n && pins_out.dq_oe_n)
        else $error("zero latency pins driven");
endmodule : rsbl_lanes_monitor
bind rsbl_lanes rsbl_lanes_monitor rsbl_lanes_monitor_i (.*);

// ===== dv/rsbl_master.sv
`timescale 1ns/1ps
// ==========
// bus master model, moves on bench falling edges
module rsbl_master (
    input  wire logic       sys_clk_in,    // clock
    output logic            bus_clock_out, // link clock
    output logic            cs_n_out,      // select
    output logic            strobe_out,    // mask
    output logic [7:0]      dq_out         // data
);
    initial begin
        {bus_clock_out, cs_n_out, strobe_out, dq_out} = 11'h35a;
    end
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : step
    task automatic half(input logic lvl);
        bus_clock_out = lvl;
        step(5);
    endtask : half
    task automatic sel(input logic v);
        cs_n_out = v;
        step(3);
    endtask : sel
    // bytes change mid-way between edges, so each is centred
    task automatic word(input logic [7:0] a, b, input logic [1:0] m,
                        input logic en);
        dq_out = a;
        strobe_out = en ? m[1] : ~strobe_out;
        step(2);
        bus_clock_out = 1'h1;
        step(3);
        dq_out = b;
        strobe_out = en ? m[0] : ~strobe_out;
        step(2);
        bus_clock_out = 1'h0;
        step(3);
        // released data flips so a stale byte never looks valid
        dq_out = ~b;
        strobe_out = en ? 1'h0 : ~strobe_out;
    endtask : word
endmodule : rsbl_master

// ===== dv/tb.sv
`timescale 1ns/1ps
// ==========
// select, then write table, command-address, read and reset cases
module tb;
    typedef struct packed {
        rsbl_pkg::rsbl_phase_t ph;
        logic [7:0]            a;
        logic [7:0]            b;
        logic [1:0]            m;
        logic [1:0]            be;
    } rsbl_row_t;
    localparam rsbl_pkg::rsbl_phase_t WR = rsbl_pkg::RSBL_PH_WRITE;
    localparam rsbl_pkg::rsbl_phase_t ZL = rsbl_pkg::RSBL_PH_WRITE_ZL;
    localparam rsbl_row_t ROWS [6] = '{'{WR, 8'ha5, 8'h3c, 2'h0, 2'h3},
        '{WR, 8'h12, 8'h34, 2'h2, 2'h1}, '{WR, 8'h56, 8'h78, 2'h1, 2'h2},
        '{WR, 8'h9a, 8'hbc, 2'h3, 2'h0}, '{ZL, 8'hde, 8'hf0, 2'h3, 2'h3},
        '{ZL, 8'h0f, 8'he1, 2'h0, 2'h3}};
    localparam logic [15:0] RDS [2] = '{16'hc396, 16'h1e2d};
    logic                    sys_clk = 1'h0;
    logic                    rst = 1'h1;
    logic                    xl = 1'h0;
    logic [15:0]             rdw = 16'h0000;
    rsbl_pkg::rsbl_phase_t   ph = rsbl_pkg::RSBL_PH_IDLE;
    logic                    bck, csn, ms, take, wv, csa;
    logic [7:0]              md;
    rsbl_pkg::rsbl_pins_t    pins;
    rsbl_pkg::rsbl_wr_word_t ww;
    rsbl_pkg::rsbl_wr_word_t got = rsbl_pkg::WR_IDLE;
    int                      bad_count = 0;
    int                      samples_checked = 0;
    int                      cyc = 0;
    wire logic [7:0] dq_w = pins.dq_oe_n ? md : pins.dq;
    wire logic       st_w = pins.strobe_oe_n ? ms : pins.strobe;
    rsbl_master rsbl_master_i (.sys_clk_in(sys_clk), .bus_clock_out(bck),
        .cs_n_out(csn), .strobe_out(ms), .dq_out(md));
    rsbl_lanes rsbl_lanes_i (.sys_clk_in(sys_clk), .rst_in(rst),
        .bus_clock_in(bck), .cs_n_in(csn), .dq_in(dq_w), .strobe_in(st_w),
        .phase_in(ph), .extra_lat_in(xl), .rd_word_in(rdw), .pins_out(pins),
        .rd_take_out(take), .wr_word_out(ww), .wr_valid_out(wv),
        .cs_active_out(csa));
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (wv) got <= ww;
        if (cyc == 5000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 1'h0;
        rsbl_master_i.step(3);
        chk("idle pins", 16'(pins), 16'(rsbl_pkg::PINS_IDLE));
        rsbl_master_i.sel(1'h0);
        chk("select", 16'(csa), 16'h0001);
        foreach (ROWS[i]) begin
            ph = ROWS[i].ph;
            rsbl_master_i.word(ROWS[i].a, ROWS[i].b, ROWS[i].m, ph == WR);
            rsbl_master_i.step(3);
            chk("wr data", got.data, {ROWS[i].a, ROWS[i].b});
            chk("wr mask", 16'(got.byte_en), 16'(ROWS[i].be));
            $display("row %0d end", i);
        end
        ph = rsbl_pkg::RSBL_PH_CA;
        for (int v = 0; v < 2; v++) begin
            xl = v[0];
            rsbl_master_i.step(3);
            chk("ca strobe", 16'({pins.strobe_oe_n, pins.strobe}),
                16'(v));
        end
        ph = rsbl_pkg::RSBL_PH_LATENCY;
        rsbl_master_i.step(3);
        chk("lat release", 16'(pins.strobe_oe_n), 16'h0001);
        $display("ca end");
        ph = rsbl_pkg::RSBL_PH_READ;
        foreach (RDS[i]) begin
            rdw = RDS[i];
            rsbl_master_i.half(1'h1);
            chk("rd hi", 16'({pins.dq_oe_n, pins.strobe, pins.dq}),
                {8'h01, RDS[i][15:8]});
            rsbl_master_i.half(1'h0);
            chk("rd lo", 16'({pins.dq_oe_n, pins.strobe, pins.dq}),
                {8'h00, RDS[i][7:0]});
        end
        $display("read end");
        rst = 1'h1;
        rsbl_master_i.step(2);
        chk("reset pins", 16'(pins), 16'(rsbl_pkg::PINS_IDLE));
        chk("reset word", ww.data, 16'h0000);
        chk("reset pulses", 16'({wv, take, csa}), 16'h0000);
        rsbl_master_i.sel(1'h1);
        rst = 1'h0;
        rsbl_master_i.step(1);
        chk("post reset sel", 16'(csa), 16'h0000);
        rsbl_master_i.step(2);
        chk("post reset pins", 16'({csa, pins}),
            16'(rsbl_pkg::PINS_IDLE));
        $display("reset end");
        complete_run();
    end
endmodule : tb
